// >>> common/pwr_mon_pkg.sv
// constants and types for the mainframe power monitor and reset sequencer
package pwr_mon_pkg;
    localparam int CLK_HZ = 40000000;
    localparam int SUPPLY_SETTLE_MS = 2;
    localparam int ACFAIL_LEAD_MS = 8;
    localparam int RAIL_LEAD_MS = 10;
    localparam int SUPPLY_SETTLE_CYC = (CLK_HZ / 1000) * SUPPLY_SETTLE_MS;
    localparam int ACFAIL_LEAD_CYC = (CLK_HZ / 1000) * ACFAIL_LEAD_MS;
    localparam int REF_HZ = 10000000;
    localparam int REF_HALF_CYC = CLK_HZ / REF_HZ / 2;
    localparam int SLOT_COUNT = 12;
    localparam int CNT_W = 24;

    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_SETTLE = 2'b01,
        ST_RUN = 2'b10,
        ST_WARN = 2'b11
    } seq_state_t;
endpackage

// >>> design/delay_counter.sv
// loadable down counter that flags when a timed interval has run out
`timescale 1ns/1ps
module delay_counter #(
    parameter int WIDTH = 24
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    output logic expired
);
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;

    // count down to zero and hold there; load restarts the interval
    always_comb begin
        count_next = count_reg;
        if (load) begin
            count_next = load_value;
        end else if (count_reg != '0) begin
            count_next = count_reg - WIDTH'(1);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count_reg <= '1;
        end else begin
            count_reg <= count_next;
        end
    end

    assign expired = (count_reg == '0) && !load;
endmodule

// >>> design/power_monitor.sv
// power monitor: backplane reset and ac-fail sequencing plus reference clock fan-out
//
// What this block does
// - hold system reset asserted while power is coming up.
// - before supplies vanish, assert ac-fail and then system reset.
// - ac-fail leads system reset by at least 8 ms after a power-fail warning, unless supplies are lost first.
// - release reset only after supplies are good for 2 ms.
// - both bus clock and 10 MHz clock valid before reset release.
// - slow clock generators may keep reset asserted until their clocks are good.
// - no automatic slot identification; slot position comes from module id lines.
// - system-controller detection and module id lines never gate each other.
// - source the 10 MHz reference clock from an accurate oscillator.
// - optionally derive the 10 MHz clock from an external reference.
// - fan the 10 MHz clock out separately to each of slots 1 to 12.
`timescale 1ns/1ps
module power_monitor
    import pwr_mon_pkg::*;
#(
    parameter int SETTLE_CYCLES = SUPPLY_SETTLE_CYC,
    parameter int LEAD_CYCLES = ACFAIL_LEAD_CYC,
    parameter int SLOTS = SLOT_COUNT
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic supply_good,
    input wire logic power_fail_warn,
    input wire logic bus_clk_valid,
    input wire logic ref_clk_valid,
    input wire logic ext_ref_sel,
    input wire logic ext_ref_in,
    output logic sys_reset_n,
    output logic ac_fail_n,
    output logic [SLOTS-1:0] ref_clk_slot
);
    seq_state_t state_reg;
    seq_state_t state_next;
    logic sys_reset_n_reg;
    logic sys_reset_n_next;
    logic ac_fail_n_reg;
    logic ac_fail_n_next;
    logic timer_load;
    logic [CNT_W-1:0] timer_value;
    logic timer_expired;
    logic clocks_valid;
    logic supply_lost;
    logic settle_done;
    logic warn_taken;
    logic lead_done;

    // both clocks must be good; a slow generator simply holds its valid low
    assign clocks_valid = bus_clk_valid && ref_clk_valid;

    // named conditions; supply loss outranks every other event
    assign supply_lost = !supply_good;
    assign settle_done = timer_expired && clocks_valid;
    assign warn_taken = supply_good && power_fail_warn;
    assign lead_done = timer_expired;

    // one timer serves the settle interval and the ac-fail lead interval
    delay_counter #(
        .WIDTH(CNT_W)
    ) u_timer (
        .clk(clk),
        .reset(reset),
        .load(timer_load),
        .load_value(timer_value),
        .expired(timer_expired)
    );

    // next state: reset until supplies good, settle, run, warn, back to reset
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RESET: begin
                // reset asserted while supplies are not yet good
                if (supply_good) begin
                    state_next = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (supply_lost) begin
                    state_next = ST_RESET;
                end else if (settle_done) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (supply_lost) begin
                    // supply already gone: no time left for a lead
                    state_next = ST_RESET;
                end else if (warn_taken) begin
                    state_next = ST_WARN;
                end
            end
            ST_WARN: begin
                // reset follows after the lead time, or at once on supply loss
                if (lead_done || supply_lost) begin
                    state_next = ST_RESET;
                end
            end
            default: begin
                state_next = ST_RESET;
            end
        endcase
    end

    // timer requests decode from the current state only, never from state_next,
    // so the expired flag cannot loop back into its own load
    always_comb begin
        timer_load = 1'b0;
        timer_value = CNT_W'(SETTLE_CYCLES);
        case (state_reg)
            ST_RESET: begin
                timer_load = supply_good;
            end
            ST_RUN: begin
                if (warn_taken) begin
                    timer_load = 1'b1;
                    timer_value = CNT_W'(LEAD_CYCLES);
                end
            end
            default: begin
                timer_load = 1'b0;
            end
        endcase
    end

    // line levels for the next cycle, decoded from the transition being taken
    always_comb begin
        sys_reset_n_next = 1'b0;
        ac_fail_n_next = 1'b1;
        case (state_next)
            ST_RUN: begin
                sys_reset_n_next = 1'b1;
            end
            ST_WARN: begin
                // warning goes out first; reset stays released for the lead
                sys_reset_n_next = 1'b1;
                ac_fail_n_next = 1'b0;
            end
            ST_RESET: begin
                // falling out of run drops both lines together; out of warn ac-fail just stays low
                if (state_reg == ST_RUN || state_reg == ST_WARN) begin
                    ac_fail_n_next = 1'b0;
                end
            end
            default: begin
                sys_reset_n_next = 1'b0; // settling holds reset
            end
        endcase
    end

    // state and both line levels move together on each edge
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= ST_RESET;
            sys_reset_n_reg <= 1'b0;
            ac_fail_n_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            sys_reset_n_reg <= sys_reset_n_next;
            ac_fail_n_reg <= ac_fail_n_next;
        end
    end

    // ac-fail released again one cycle after reset drops, whether or not power has returned
    assign sys_reset_n = sys_reset_n_reg;
    assign ac_fail_n = ac_fail_n_reg;

    // 10 MHz reference: internal divider, guarded source choice, slot drivers
    logic [1:0] div_reg;
    logic [1:0] div_next;
    logic ref_int_reg;
    logic ref_int_next;
    logic use_ext_reg;
    logic use_ext_next;
    logic ref_src;
    wire logic [SLOTS-1:0] slot_bus;

    // divide 40 MHz by four; accuracy is that of the board oscillator
    always_comb begin
        div_next = div_reg + 2'(1);
        ref_int_next = ref_int_reg;
        if (div_reg == 2'(REF_HALF_CYC - 1)) begin
            div_next = '0;
            ref_int_next = ~ref_int_reg;
        end
    end

    // divider state
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            div_reg <= '0;
            ref_int_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            ref_int_reg <= ref_int_next;
        end
    end

    // source changes only while both candidates sit at one level, so a switch
    // never chops a runt pulse onto the slots; waits at most one half period
    always_comb begin
        use_ext_next = use_ext_reg;
        if (ext_ref_sel != use_ext_reg && ext_ref_in == ref_int_reg) begin
            use_ext_next = ext_ref_sel;
        end
    end

    // source choice state
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            use_ext_reg <= 1'b0;
        end else begin
            use_ext_reg <= use_ext_next;
        end
    end

    // external input taken as synchronous, per pin convention
    assign ref_src = use_ext_reg ? ext_ref_in : ref_int_reg;

    // one flop per slot so each slot has its own driver
    for (genvar i = 0; i < SLOTS; i++) begin : g_slot
        logic drv_reg;
        logic drv_next;

        // every slot copies the chosen source
        always_comb begin
            drv_next = ref_src;
        end

        // private driver flop for this slot
        always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
                drv_reg <= 1'b0;
            end else begin
                drv_reg <= drv_next;
            end
        end

        assign slot_bus[i] = drv_reg;
    end

    // no slot probing or controller detection here; module id lines stay elsewhere
    assign ref_clk_slot = slot_bus;
endmodule

// >>> tb/power_monitor_sva.sv
// checker for the power monitor reset sequencer
`timescale 1ns/1ps
module power_monitor_sva #(
    parameter int SETTLE_CYCLES = 20,
    parameter int LEAD_CYCLES = 50,
    parameter int SLOTS = 12
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic supply_good,
    input wire logic power_fail_warn,
    input wire logic bus_clk_valid,
    input wire logic ref_clk_valid,
    input wire logic sys_reset_n,
    input wire logic ac_fail_n,
    input wire logic [SLOTS-1:0] ref_clk_slot
);
    int good_cnt;
    int lead_cnt;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // edges with supplies good, and edges with ac fail low
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            good_cnt <= 0;
            lead_cnt <= 0;
        end else begin
            good_cnt <= supply_good ? good_cnt + 1 : 0;
            lead_cnt <= ac_fail_n ? 0 : lead_cnt + 1;
        end
    end
    sequence s_run_warn;
        sys_reset_n && ac_fail_n && supply_good && power_fail_warn;
    endsequence
    sequence s_warn_cut;
        $fell(sys_reset_n) && $past(supply_good);
    endsequence
    property p_rel; $rose(sys_reset_n) |-> good_cnt >= SETTLE_CYCLES; endproperty
    property p_clk; $rose(sys_reset_n) |-> $past(bus_clk_valid && ref_clk_valid); endproperty
    property p_loss; !supply_good |=> !sys_reset_n; endproperty
    property p_warn; s_run_warn |=> !ac_fail_n; endproperty
    property p_lead; s_warn_cut |-> lead_cnt >= LEAD_CYCLES; endproperty
    property p_drop; !ac_fail_n && sys_reset_n |-> lead_cnt <= LEAD_CYCLES; endproperty
    property p_back; s_warn_cut ##0 !ac_fail_n |=> ac_fail_n; endproperty
    property p_hold; !sys_reset_n && !bus_clk_valid |=> !sys_reset_n; endproperty
    property p_fan; ref_clk_slot == '0 || ref_clk_slot == '1; endproperty
    a_rel: assert property (p_rel) else $error("early release");
    a_clk: assert property (p_clk) else $error("release without clocks");
    a_loss: assert property (p_loss) else $error("reset not held");
    a_warn: assert property (p_warn) else $error("no ac fail");
    a_lead: assert property (p_lead) else $error("short lead");
    a_drop: assert property (p_drop) else $error("reset not cut");
    a_back: assert property (p_back) else $error("ac fail stuck");
    a_hold: assert property (p_hold) else $error("clock gate lost");
    a_fan: assert property (p_fan) else $error("slots differ");
endmodule
bind power_monitor power_monitor_sva #(
    .SETTLE_CYCLES(SETTLE_CYCLES),
    .LEAD_CYCLES(LEAD_CYCLES),
    .SLOTS(SLOTS)
) u_sva (
    .clk(clk),
    .reset(reset),
    .supply_good(supply_good),
    .power_fail_warn(power_fail_warn),
    .bus_clk_valid(bus_clk_valid),
    .ref_clk_valid(ref_clk_valid),
    .sys_reset_n(sys_reset_n),
    .ac_fail_n(ac_fail_n),
    .ref_clk_slot(ref_clk_slot)
);

// >>> tb/plug_in_module.sv
// plug-in module that sequences its own supplies
`timescale 1ns/1ps
module plug_in_module (
    input wire logic clk,
    input wire logic sys_reset_n,
    output logic seq_on
);
    // starts only once reset is seen released; no slot or controller probing
    always_ff @(posedge clk) begin
        seq_on <= sys_reset_n;
    end
endmodule

// >>> tb/power_monitor_bench.sv
// self-checking bench for the power monitor
`timescale 1ns/1ps
`define CHK(nm, e, a) begin check_count++; if ((a) !== (e)) begin fail_count++; \
    $display("unexpected %s exp %0h got %0h", nm, e, a); end end
module power_monitor_bench;
    import pwr_mon_pkg::*;
    localparam int SC = 20;
    localparam int LC = 50;
    logic clk = 0, reset = 1, supply_good = 0, power_fail_warn = 0;
    logic bus_clk_valid = 0, ref_clk_valid = 0, ext_ref_sel = 0, ext_ref_in = 0;
    logic sys_reset_n, ac_fail_n, seq_on, p;
    logic [SLOT_COUNT-1:0] ref_clk_slot;
    int fail_count = 0, check_count = 0, n;
    always #12.5 clk = ~clk;
    power_monitor #(.SETTLE_CYCLES(SC), .LEAD_CYCLES(LC)) u_dut (.clk(clk), .reset(reset),
        .supply_good(supply_good), .power_fail_warn(power_fail_warn),
        .bus_clk_valid(bus_clk_valid), .ref_clk_valid(ref_clk_valid),
        .ext_ref_sel(ext_ref_sel), .ext_ref_in(ext_ref_in), .sys_reset_n(sys_reset_n),
        .ac_fail_n(ac_fail_n), .ref_clk_slot(ref_clk_slot));
    plug_in_module u_mod (.clk(clk), .sys_reset_n(sys_reset_n), .seq_on(seq_on));
    // inputs move only after the falling edge
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic t_up;
        supply_good = 1;
        cyc(SC + 6);
        `CHK("no clocks", 1'b0, sys_reset_n)
        bus_clk_valid = 1;
        cyc(4);
        `CHK("no ref clock", 1'b0, sys_reset_n)
        ref_clk_valid = 1;
        cyc(4);
        `CHK("release", 1'b1, sys_reset_n)
        `CHK("module on", 1'b1, seq_on)
    endtask
    task automatic t_ref;
        p = ref_clk_slot[0];
        n = 0;
        repeat (40) begin
            cyc(1);
            n += int'(ref_clk_slot[0] != p);
            p = ref_clk_slot[0];
        end
        `CHK("ref edges", 20, n)
        ext_ref_sel = 1;
        ext_ref_in = 1;
        cyc(4);
        `CHK("ext high", {SLOT_COUNT{1'b1}}, ref_clk_slot)
        ext_ref_in = 0;
        cyc(4);
        `CHK("ext low", {SLOT_COUNT{1'b0}}, ref_clk_slot)
    endtask
    // a short supply dip must restart the full settle time
    task automatic t_dip;
        supply_good = 0;
        cyc(1);
        `CHK("dip", 2'b00, {sys_reset_n, ac_fail_n})
        supply_good = 1;
        cyc(SC);
        `CHK("settling", 1'b0, sys_reset_n)
        cyc(4);
        `CHK("again", 1'b1, sys_reset_n)
    endtask
    task automatic t_warn;
        power_fail_warn = 1;
        cyc(1);
        `CHK("warn", 2'b10, {sys_reset_n, ac_fail_n})
        power_fail_warn = 0;
        cyc(LC - 1);
        `CHK("lead", 1'b1, sys_reset_n)
        n = 0;
        while (sys_reset_n === 1'b1 && n < 20) begin
            cyc(1);
            n++;
        end
        `CHK("cut", 1'b0, sys_reset_n)
        cyc(1);
        `CHK("ac back", 1'b1, ac_fail_n)
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        cyc(10);
        `CHK("por", 2'b01, {sys_reset_n, ac_fail_n})
        reset = 0;
        t_up;
        t_ref;
        t_dip;
        t_warn;
        final_report;
    end
    // whole run is about 170 cycles
    initial begin
        #200000;
        fail_count++;
        final_report;
    end
endmodule
